// File: hw/usb_error_interrupt_logic.sv
`timescale 1ns/1ps
`include "usb_err_defines.svh"
module usb_error_interrupt_logic
   import usb_err_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `IDLE_TIME_US * `PCLK_MHZ
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire rx_ev_t      rx_ev,
   input  wire logic        vbus_pin,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             top_error_irq_flag,
   output logic             token_accept,
   output logic             module_enable,
   output logic             pullup_enable
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   apb_state_t  state_ff;
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic        pready_ff;
   logic [7:0]  err_status_ff;
   logic [7:0]  err_enable_ff;
   logic        top_err_ff;
   logic        idle_flag_ff;
   logic [2:0]  ctrl_ff;
   logic [8:0]  evt_ff;
   logic [8:0]  evt_mask_ff;
   logic        irq_ff;
   logic        token_ok_ff;
   logic        pullup_ff;
   logic        mod_en_ff;
   logic        vbus_s1_ff;
   logic        vbus_s2_ff;
   logic        vbus_s3_ff;
   logic        vbus_ff;

   // ------------------------------------------------------------------
   // combinational
   // ------------------------------------------------------------------
   reg_sel_t    sel;
   logic        access;
   logic        fire;
   logic        wr_fire;
   logic        rd_fire;
   logic [31:0] rd_mux;
   logic        unmapped;
   logic        active;
   logic        stuff_err;
   logic        turn_err;
   logic        idle_hit;
   logic [7:0]  err_set;
   logic [7:0]  err_clr;
   logic [7:0]  nxt_err_status;
   logic [8:0]  evt_set;
   logic [8:0]  evt_clr;
   logic [8:0]  nxt_evt;
   logic        idle_clr;
   logic        nxt_idle_flag;

   // register index decode from a byte address
   function automatic reg_sel_t reg_decode(input logic [17:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[17:2])
            `ERR_ENABLE_IDX: s = SEL_ENABLE;
            `ERR_STATUS_IDX: s = SEL_STATUS;
            `MAIN_IRQ_IDX:   s = SEL_MAIN;
            `CONTROL_IDX:    s = SEL_CTRL;
            `EVENT_IDX:      s = SEL_EVT;
            `EVENT_MASK_IDX: s = SEL_MASK;
            default:         s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // sticky update where a set beats a clear in the same cycle
   function automatic logic [8:0] sticky(input logic [8:0] cur,
                                         input logic [8:0] set,
                                         input logic [8:0] clr);
      return (cur & ~clr) | set;
   endfunction

   // packet id check: upper nibble must be the complement of the lower
   function automatic logic pid_bad(input logic [7:0] p);
      return p[7:4] != ~p[3:0];
   endfunction

   // ------------------------------------------------------------------
   // apb slave: one wait state, answer from flops
   // ------------------------------------------------------------------
   assign sel      = reg_decode(paddr);
   assign unmapped = (sel == SEL_NONE);
   assign access   = psel && penable;
   assign fire     = access && state_ff == APB_DONE;
   assign wr_fire  = fire && pwrite && !unmapped;
   assign rd_fire  = fire && !pwrite && !unmapped;

   // read data; unimplemented bits read as zero
   always_comb begin
      rd_mux = 32'h0;
      case (sel)
         SEL_ENABLE: rd_mux[7:0] = err_enable_ff;
         SEL_STATUS: rd_mux[7:0] = err_status_ff;
         SEL_MAIN: begin
            rd_mux[`MAIN_IDLE_BIT] = idle_flag_ff;
            rd_mux[`MAIN_ERR_BIT]  = top_err_ff;
            rd_mux[`MAIN_VBUS_BIT] = vbus_ff;
         end
         SEL_CTRL:   rd_mux[2:0] = ctrl_ff;
         SEL_EVT:    rd_mux[8:0] = evt_ff;
         SEL_MASK:   rd_mux[8:0] = evt_mask_ff;
         default:    rd_mux = 32'h0;
      endcase
   end

   // phase tracking and registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         state_ff   <= APB_WAIT;
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end else begin
         case (state_ff)
            APB_WAIT: begin
               if (access) begin
                  pready_ff  <= 1'b1;
                  state_ff   <= APB_DONE;
                  prdata_ff  <= pwrite ? 32'h0 : rd_mux;
                  pslverr_ff <= unmapped;
               end
            end
            APB_DONE: begin
               pready_ff  <= 1'b0;
               state_ff   <= APB_WAIT;
               prdata_ff  <= 32'h0;
               pslverr_ff <= 1'b0;
            end
            default: begin
               pready_ff  <= 1'b0;
               state_ff   <= APB_WAIT;
               prdata_ff  <= 32'h0;
               pslverr_ff <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // error detection
   // ------------------------------------------------------------------
   assign active = mod_en_ff && !ctrl_ff[`CTL_SUSPEND];

   link_idle_monitor #(
      .IDLE_CYCLES (IDLE_CYCLES)
   ) u_monitor (
      .pclk      (pclk),
      .presetn   (presetn),
      .active    (active),
      .ev        (rx_ev),
      .stuff_err (stuff_err),
      .turn_err  (turn_err),
      .idle_hit  (idle_hit)
   );

   // conditions raised the cycle they are seen, enables not consulted
   always_comb begin
      err_set = 8'h0;
      err_set[`BIT_STUFF] = stuff_err;
      err_set[`BIT_TURN]  = turn_err;
      err_set[`BIT_FSIZE] = active && rx_ev.data_end && rx_ev.data_bits_mod8 != 3'h0;
      err_set[`BIT_CRC16] = active && rx_ev.data_end && !rx_ev.crc16_ok;
      err_set[`BIT_CRC5]  = active && rx_ev.token_end && !rx_ev.crc5_ok;
      err_set[`BIT_PID]   = active && rx_ev.pid_valid && pid_bad(rx_ev.pid);
   end

   // a zero written clears; a one leaves the bit alone
   assign err_clr = (wr_fire && sel == SEL_STATUS && pstrb[0]) ?
                    ~pwdata[7:0] : 8'h0;

   assign nxt_err_status = 8'(sticky({1'b0, err_status_ff}, {1'b0, err_set},
                                     {1'b0, err_clr})) & `ERR_IMPL_MASK;

   // error status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_status_ff <= 8'h0;
      end else begin
         err_status_ff <= nxt_err_status;
      end
   end

   // error enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_enable_ff <= 8'h0;
      end else if (wr_fire && sel == SEL_ENABLE && pstrb[0]) begin
         err_enable_ff <= pwdata[7:0] & `ERR_IMPL_MASK;
      end
   end

   // top error flag follows the gated flags only, never a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_err_ff <= 1'b0;
      end else begin
         top_err_ff <= |(err_status_ff & err_enable_ff);
      end
   end

   // ------------------------------------------------------------------
   // idle detect flag in the main status word
   // ------------------------------------------------------------------
   // zero written to the idle bit clears it; a new hit wins
   assign idle_clr = wr_fire && sel == SEL_MAIN && pstrb[0] && !pwdata[`MAIN_IDLE_BIT];
   assign nxt_idle_flag = idle_hit || (idle_flag_ff && !idle_clr);

   // sticky idle flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_flag_ff <= 1'b0;
      end else begin
         idle_flag_ff <= nxt_idle_flag;
      end
   end

   // ------------------------------------------------------------------
   // control: module enable, pull-up, suspend
   // ------------------------------------------------------------------
   // software control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= 3'h0;
      end else if (wr_fire && sel == SEL_CTRL && pstrb[0]) begin
         ctrl_ff <= pwdata[2:0];
      end
   end

   // pull-up ignores suspend so attachment stays visible
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_en_ff <= 1'b0;
         pullup_ff <= 1'b0;
      end else begin
         mod_en_ff <= ctrl_ff[`CTL_MOD_EN];
         pullup_ff <= ctrl_ff[`CTL_PULLUP] && ctrl_ff[`CTL_MOD_EN];
      end
   end

   // supply sense: three stages, change taken when last two agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vbus_s1_ff <= 1'b0;
         vbus_s2_ff <= 1'b0;
         vbus_s3_ff <= 1'b0;
         vbus_ff    <= 1'b0;
      end else begin
         vbus_s1_ff <= vbus_pin;
         vbus_s2_ff <= vbus_s1_ff;
         vbus_s3_ff <= vbus_s2_ff;
         if (vbus_s2_ff == vbus_s3_ff) begin
            vbus_ff <= vbus_s3_ff;
         end
      end
   end

   // ------------------------------------------------------------------
   // token acceptance pulse
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         token_ok_ff <= 1'b0;
      end else begin
         token_ok_ff <= active && rx_ev.token_end && rx_ev.crc5_ok;
      end
   end

   // ------------------------------------------------------------------
   // interrupt events: read clears, set wins
   // ------------------------------------------------------------------
   assign evt_set = {idle_hit, err_set & `ERR_IMPL_MASK};
   assign evt_clr = (rd_fire && sel == SEL_EVT) ? 9'h1ff : 9'h0;
   assign nxt_evt = sticky(evt_ff, evt_set, evt_clr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_ff <= 9'h0;
      end else begin
         evt_ff <= nxt_evt;
      end
   end

   // event mask, both byte lanes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_mask_ff <= 9'h0;
      end else if (wr_fire && sel == SEL_MASK) begin
         if (pstrb[0]) begin
            evt_mask_ff[7:0] <= pwdata[7:0] & `ERR_IMPL_MASK;
         end
         if (pstrb[1]) begin
            evt_mask_ff[`EVT_IDLE_BIT] <= pwdata[`EVT_IDLE_BIT];
         end
      end
   end

   // level interrupt while an unmasked event is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(evt_ff & evt_mask_ff);
      end
   end

   // ------------------------------------------------------------------
   // outputs, each straight from a flop
   // ------------------------------------------------------------------
   assign prdata             = prdata_ff;
   assign pready             = pready_ff;
   assign pslverr            = pslverr_ff;
   assign irq                = irq_ff;
   assign top_error_irq_flag = top_err_ff;
   assign token_accept       = token_ok_ff;
   assign module_enable      = mod_en_ff;
   assign pullup_enable      = pullup_ff;

endmodule // usb_error_interrupt_logic

// File: hw/usb_err_defines.svh
`ifndef USB_ERR_DEFINES_SVH
`define USB_ERR_DEFINES_SVH

// register indices; byte address is four times the index
`define ERR_ENABLE_IDX  16'h0f37
`define ERR_STATUS_IDX  16'h0f63
`define MAIN_IRQ_IDX    16'h0f64
`define CONTROL_IDX     16'h0f65
`define EVENT_IDX       16'h0f66
`define EVENT_MASK_IDX  16'h0f67

// error register layout
`define ERR_IMPL_MASK   8'h9f
`define BIT_STUFF       7
`define BIT_TURN        4
`define BIT_FSIZE       3
`define BIT_CRC16       2
`define BIT_CRC5        1
`define BIT_PID         0

// main status, control and event layout
`define MAIN_IDLE_BIT   4
`define MAIN_ERR_BIT    1
`define MAIN_VBUS_BIT   8
`define CTL_MOD_EN      0
`define CTL_PULLUP      1
`define CTL_SUSPEND     2
`define EVT_IDLE_BIT    8

// timing
`define STUFF_RUN       3'h6
`define TURN_BIT_TIMES  5'h10
`define IDLE_TIME_US    3000
`define PCLK_MHZ        50
`endif

// File: hw/usb_err_pkg.sv
package usb_err_pkg;

   // same-clock event bundle from the receive datapath
   typedef struct packed {
      logic       bit_tick;
      logic       rx_bit;
      logic       line_idle;
      logic       eop;
      logic       expect_response;
      logic       data_end;
      logic [2:0] data_bits_mod8;
      logic       crc16_ok;
      logic       token_end;
      logic       crc5_ok;
      logic       pid_valid;
      logic [7:0] pid;
   } rx_ev_t;

   typedef enum logic [2:0] {
      SEL_NONE   = 3'b000,
      SEL_ENABLE = 3'b001,
      SEL_STATUS = 3'b010,
      SEL_MAIN   = 3'b011,
      SEL_CTRL   = 3'b100,
      SEL_EVT    = 3'b101,
      SEL_MASK   = 3'b110
   } reg_sel_t;

   typedef enum logic [0:0] {
      APB_WAIT = 1'b0,
      APB_DONE = 1'b1
   } apb_state_t;

endpackage

// File: hw/link_idle_monitor.sv
`timescale 1ns/1ps
`include "usb_err_defines.svh"
module link_idle_monitor
   import usb_err_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `IDLE_TIME_US * `PCLK_MHZ
) (
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   active,
   input  wire rx_ev_t ev,
   output logic        stuff_err,
   output logic        turn_err,
   output logic        idle_hit
);
   logic [2:0]  ones_ff;
   logic        armed_ff;
   logic [4:0]  turn_cnt_ff;
   logic [19:0] idle_cnt_ff;
   logic        stuff_err_ff;
   logic        turn_err_ff;
   logic        idle_hit_ff;

   // run of ones; a one after six is a stuffing violation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ones_ff      <= 3'h0;
         stuff_err_ff <= 1'b0;
      end else begin
         stuff_err_ff <= active && ev.bit_tick && ev.rx_bit && ones_ff == `STUFF_RUN;
         if (ev.eop || !active) begin
            ones_ff <= 3'h0;
         end else if (ev.bit_tick) begin
            ones_ff <= (ev.rx_bit && ones_ff != `STUFF_RUN) ? ones_ff + 3'h1 : 3'h0;
         end
      end
   end

   // turnaround: idle bit times after an eop while a response is due
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_ff    <= 1'b0;
         turn_cnt_ff <= 5'h0;
         turn_err_ff <= 1'b0;
      end else begin
         turn_err_ff <= 1'b0;
         if (!active || !ev.line_idle) begin
            armed_ff <= 1'b0;
         end else if (ev.eop) begin
            armed_ff    <= ev.expect_response;
            turn_cnt_ff <= 5'h0;
         end else if (armed_ff && ev.bit_tick) begin
            if (turn_cnt_ff == `TURN_BIT_TIMES) begin
               turn_err_ff <= 1'b1;
               armed_ff    <= 1'b0;
            end else begin
               turn_cnt_ff <= turn_cnt_ff + 5'h1;
            end
         end
      end
   end

   // idle timer, one pulse per idle stretch longer than the limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_ff <= 20'h0;
         idle_hit_ff <= 1'b0;
      end else begin
         idle_hit_ff <= ev.line_idle && idle_cnt_ff == 20'(IDLE_CYCLES);
         if (!ev.line_idle) begin
            idle_cnt_ff <= 20'h0;
         end else if (idle_cnt_ff != 20'(IDLE_CYCLES) + 20'h1) begin
            idle_cnt_ff <= idle_cnt_ff + 20'h1;
         end
      end
   end

   assign stuff_err = stuff_err_ff;
   assign turn_err  = turn_err_ff;
   assign idle_hit  = idle_hit_ff;
endmodule // link_idle_monitor

// File: tb/usb_err_properties.sv
`timescale 1ns/1ps
module usb_err_properties
   import usb_err_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = 60
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire rx_ev_t      rx_ev,
   input wire logic        vbus_pin,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        top_error_irq_flag,
   input wire logic        token_accept,
   input wire logic        module_enable,
   input wire logic        pullup_enable
);
   // any receive pulse that can raise a flag, and a finished transfer
   wire ev_any = rx_ev.pid_valid | rx_ev.token_end | rx_ev.data_end | rx_ev.bit_tick;
   wire done   = psel & penable & pready;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // access phase waiting, then a one-cycle answer
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   a_ready_one_wait: assert property (s_wait |=> s_answer)
      else $error("pready not one cycle after access phase");
   a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read answer");
   a_slverr_align: assert property (done && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access not refused");
   a_bad_token: assert property (
      rx_ev.token_end && !rx_ev.crc5_ok |=> !token_accept)
      else $error("token with bad crc accepted");
   a_top_rise_cause: assert property (
      $rose(top_error_irq_flag) |-> $past(done && pwrite, 2) || $past(ev_any, 2)
                                    || $past(ev_any, 3))
      else $error("top flag rose without error or enable write");
   a_top_fall_cause: assert property (
      $fell(top_error_irq_flag) |-> $past(done && pwrite, 2))
      else $error("top flag fell without a write");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(done, 2))
      else $error("irq fell without a transfer");
   a_pullup_module: assert property (pullup_enable |-> module_enable)
      else $error("pull-up on while module off");
endmodule // usb_err_properties

// File: tb/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model
   import usb_err_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = 60
) (
   input  wire logic pclk,
   output rx_ev_t    ev,
   output logic      vbus_pin
);
   initial begin
      ev       = '0;
      vbus_pin = 1'b0;
   end

   // drive one cycle of receive signals, called just after an edge
   task automatic step(input rx_ev_t v);
      ev <= v;
      @(posedge pclk);
   endtask

   // host starts driving the supply
   task automatic attach();
      vbus_pin <= 1'b1;
   endtask

   // 0 pid, 1 crc5, 2 crc16, 3 size, 4 no turnaround, 5 stuffing, 6 good token, 7 silence
   task automatic send(input int k);
      rx_ev_t v;
      v                 = '0;
      v.pid_valid       = (k == 0) || (k == 6);
      v.pid             = (k == 0) ? 8'h33 : 8'h5a; // 33 fails the nibble check, 5a passes
      v.token_end       = (k == 1) || (k == 6);
      v.crc5_ok         = (k != 1);
      v.data_end        = (k == 2) || (k == 3);
      v.crc16_ok        = (k != 2);
      v.data_bits_mod8  = (k == 3) ? 3'h5 : 3'h0;
      v.line_idle       = (k == 4) || (k == 7);
      v.eop             = (k == 4);
      v.expect_response = (k == 4);
      v.rx_bit          = (k == 5);
      step(v);
      v.pid_valid = 1'b0;
      v.token_end = 1'b0;
      v.data_end  = 1'b0;
      v.eop       = 1'b0;
      // bit times with no answer, or a run of ones
      repeat ((k == 4) ? 17 : ((k == 5) ? 7 : 0)) begin
         v.bit_tick = 1'b1;
         step(v);
         v.bit_tick = 1'b0;
         step(v);
      end
      if (k == 7) begin
         repeat (IDLE_CYCLES + 4) step(v);
      end
      step('0);
   endtask
endmodule // usb_host_model

// File: tb/usb_error_interrupt_logic_test.sv
`timescale 1ns/1ps
`include "usb_err_defines.svh"
module usb_error_interrupt_logic_test
   import usb_err_pkg::*;
;
   localparam int unsigned IDLE = 60;
   localparam logic [17:0] ENA  = {`ERR_ENABLE_IDX, 2'b00};
   localparam logic [17:0] STA  = {`ERR_STATUS_IDX, 2'b00};
   localparam logic [17:0] MAIN = {`MAIN_IRQ_IDX, 2'b00};
   localparam logic [17:0] CTRL = {`CONTROL_IDX, 2'b00};
   localparam logic [17:0] EVT  = {`EVENT_IDX, 2'b00};
   localparam logic [17:0] MSK  = {`EVENT_MASK_IDX, 2'b00};

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   rx_ev_t      rx_ev;
   logic        vbus_pin;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, top_error_irq_flag;
   logic        token_accept, module_enable, pullup_enable;
   logic [31:0] rdata, exp, tok_seen = 32'h0;
   logic        serr;
   int          checked = 0, fail_count = 0, n, b;

   always #10 pclk = ~pclk;

   // count accepted tokens
   always @(posedge pclk) if (token_accept === 1'b1) tok_seen <= tok_seen + 32'h1;

   usb_host_model #(.IDLE_CYCLES(IDLE)) host (.pclk(pclk), .ev(rx_ev), .vbus_pin(vbus_pin));

   usb_error_interrupt_logic #(.IDLE_CYCLES(IDLE)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .rx_ev(rx_ev), .vbus_pin(vbus_pin),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .top_error_irq_flag(top_error_irq_flag), .token_accept(token_accept),
      .module_enable(module_enable), .pullup_enable(pullup_enable));

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   // one transfer, started just after an edge
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         fail_count++;
         conclude();
      end
      rdata = prdata;
      serr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk); // idle cycle, so the next call starts clean
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, unused bits, refused places
      apb(1'b0, ENA, 32'h0);
      check("enable reset", rdata, 32'h0);
      apb(1'b0, STA, 32'h0);
      check("status reset", rdata, 32'h0);
      apb(1'b1, ENA, 32'hffffffff);
      apb(1'b0, ENA, 32'h0);
      check("enable bits", rdata, 32'h9f);
      pstrb <= 4'h0;
      apb(1'b1, ENA, 32'h0);
      pstrb <= 4'hf;
      apb(1'b0, ENA, 32'h0);
      check("strobe off", rdata, 32'h9f);
      apb(1'b0, 18'h00400, 32'h0);
      check("unmapped data", {31'h0, serr}, 32'h1);
      apb(1'b0, STA + 18'h1, 32'h0);
      check("misaligned", {31'h0, serr}, 32'h1);
      apb(1'b1, ENA, 32'h0);
      $display("test registers done");
      // module stays off until software sets the enable bit, after the supply is seen
      host.send(2);
      apb(1'b0, STA, 32'h0);
      check("ignored while off", rdata, 32'h0);
      host.attach();
      n = 0;
      do begin
         apb(1'b0, MAIN, 32'h0);
         n++;
      end while (rdata[8] !== 1'b1 && n < 20);
      check("supply seen", {31'h0, rdata[8]}, 32'h1);
      if (rdata[8] !== 1'b1) conclude();
      apb(1'b1, CTRL, 32'h3);
      repeat (2) @(posedge pclk);
      check("module on", {30'h0, pullup_enable, module_enable}, 32'h3);
      // every error kind with its enable off
      exp = 32'h0;
      for (int k = 0; k < 6; k++) begin
         host.send(k);
         exp[(k == 5) ? 7 : k] = 1'b1;
         apb(1'b0, STA, 32'h0);
         check("error flags", rdata, exp);
         check("top masked", {31'h0, top_error_irq_flag}, 32'h0);
      end
      apb(1'b1, STA, 32'hff);
      apb(1'b0, STA, 32'h0);
      check("ones keep flags", rdata, 32'h9f);
      host.send(6);
      @(posedge pclk);
      check("good token", tok_seen, 32'h1);
      apb(1'b1, ENA, 32'h9f);
      repeat (2) @(posedge pclk);
      check("top set", {31'h0, top_error_irq_flag}, 32'h1);
      apb(1'b1, MAIN, 32'h0);
      apb(1'b0, MAIN, 32'h0);
      check("main status", rdata, 32'h102);
      for (int k = 0; k < 6; k++) begin
         b = (k == 5) ? 7 : k;
         apb(1'b1, STA, ~(32'h1 << b));
         exp[b] = 1'b0;
         apb(1'b0, STA, 32'h0);
         check("flag cleared", rdata, exp);
         check("top follows", {31'h0, top_error_irq_flag}, {31'h0, exp != 32'h0});
      end
      $display("test error flags done");
      // one source enabled, event register and mask
      apb(1'b0, EVT, 32'h0);
      apb(1'b1, ENA, 32'h4);
      apb(1'b1, MSK, 32'h4);
      host.send(0);
      check("other gated", {30'h0, irq, top_error_irq_flag}, 32'h0);
      host.send(6);
      host.send(2);
      @(posedge pclk);
      check("prompt flag", {30'h0, irq, top_error_irq_flag}, 32'h3);
      apb(1'b0, EVT, 32'h0);
      check("events", rdata, 32'h5);
      repeat (2) @(posedge pclk);
      check("irq dropped", {31'h0, irq}, 32'h0);
      apb(1'b0, EVT, 32'h0);
      check("events cleared", rdata, 32'h0);
      apb(1'b1, STA, 32'h0);
      $display("test interrupts done");
      // long silence on the bus
      apb(1'b1, MSK, 32'h100);
      host.send(7);
      apb(1'b0, MAIN, 32'h0);
      check("idle flag", rdata, 32'h110);
      check("idle irq", {31'h0, irq}, 32'h1);
      apb(1'b1, MAIN, 32'h0);
      apb(1'b0, EVT, 32'h0);
      check("idle event", rdata, 32'h100);
      apb(1'b0, MAIN, 32'h0);
      check("idle cleared", rdata, 32'h100);
      $display("test idle done");
      // suspended link keeps its pull-up and ignores errors
      apb(1'b1, CTRL, 32'h7);
      host.send(2);
      apb(1'b0, STA, 32'h0);
      check("suspend ignores", rdata, 32'h0);
      check("pull-up kept", {31'h0, pullup_enable}, 32'h1);
      $display("test suspend done");
      conclude();
   end
endmodule // usb_error_interrupt_logic_test

bind usb_error_interrupt_logic usb_err_properties #(.IDLE_CYCLES(IDLE_CYCLES)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .rx_ev(rx_ev), .vbus_pin(vbus_pin),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .top_error_irq_flag(top_error_irq_flag), .token_accept(token_accept),
   .module_enable(module_enable), .pullup_enable(pullup_enable));
